/* File: rrm_pkg.sv */
/*
  Package for the receive-mode and antenna-driver control bank.
  Assumes an AXI4-Lite master with 32-bit data and a 125 MHz clock.
*/
package rrm_pkg;
  // ----------------------------------------
  // Register indices and address width
  // ----------------------------------------
  localparam logic [7:0] IDX_RX_MODE = 8'h13;
  localparam logic [7:0] IDX_DRV_CTRL = 8'h14;
  localparam logic [7:0] IDX_TX_MOD = 8'h15;
  localparam logic [7:0] IDX_RX_STATUS = 8'h16;
  localparam int ADDR_W = 10;
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_RX_MODE = 8'h00;
  localparam logic [7:0] RST_DRV_CTRL = 8'h80;
  localparam logic [7:0] RST_TX_MOD = 8'h00;
  localparam logic [7:0] MASK_RX_MODE = 8'hfc;
  localparam logic [7:0] MASK_DRV_CTRL = 8'hfb;
  localparam logic [7:0] MASK_TX_MOD = 8'h40;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RX_CRC_BIT = 7;
  localparam int RX_RATE_HI = 6;
  localparam int RX_RATE_LO = 4;
  localparam int RX_SHORT_BIT = 3;
  localparam int RX_MULTI_BIT = 2;
  localparam int DRV_B_INV_ON = 7;
  localparam int DRV_A_INV_ON = 6;
  localparam int DRV_B_INV_OFF = 5;
  localparam int DRV_A_INV_OFF = 4;
  localparam int DRV_B_CW = 3;
  localparam int DRV_B_EN = 1;
  localparam int DRV_A_EN = 0;
  localparam int ASK_FULL_BIT = 6;
  localparam int ERR_CRC_BIT = 1;
  localparam int MIN_FRAME_BITS = 4;
  // ----------------------------------------
  // Responses and enumerations
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] CMD_RECEIVE = 4'h8;
  localparam logic [3:0] CMD_TRANSCEIVE = 4'hc;
  typedef enum logic [2:0] {
    RATE_106 = 3'b000,
    RATE_212 = 3'b001,
    RATE_424 = 3'b010,
    RATE_848 = 3'b011
  } rrm_rate_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_ACTIVE = 2'b01,
    RX_APPEND = 2'b10
  } rrm_rx_e;
  // End-of-stream report from the bit decoder
  typedef struct packed {
    logic valid;
    logic [5:0] nbits;
  } rrm_frame_s;
  // Byte pushed into the receive FIFO
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rrm_fifo_s;
  // Driver pin control
  typedef struct packed {
    logic a_on;
    logic b_on;
    logic a_out;
    logic b_out;
  } rrm_drv_s;
endpackage

/* File: rrm_ctrl.sv */
/*
  Receive-mode and antenna-driver control bank with AXI4-Lite slave.
  Assumes a synchronous decoder, encoder and command engine on the same clock.
*/
// Contract
// RQ1: Bit 7 of receive mode enables CRC checking of received frames.
// RQ2: Software clears CRC check enable only at 106 kBd.
// RQ3: Bits 6..4 pick 106/212/424/848 kBd; codes 100..111 reserved.
// RQ4: With bit 3 set, streams under 4 bits are dropped, receiver stays on.
// RQ5: With multi-frame clear, receiver stops after one frame.
// RQ6: With multi-frame set, successive frames are accepted above 106 kBd.
// RQ7: Multi-frame receive ends only on another command or bit clear.
// RQ8: Multi-frame appends a copy of the error flags after each stream.
// RQ9: Newer revision reports good CRC in error byte; older reports failure.
// RQ10: Bits 7,6 invert driver B,A output while that driver is enabled.
// RQ11: Bits 5,4 invert driver B,A output while that driver is disabled.
// RQ12: Bit 3 makes driver B send unmodulated carrier; clear means modulated.
// RQ13: Bit 1 makes driver B send carrier modulated by transmit data.
// RQ14: Bit 0 makes driver A send carrier modulated by transmit data.
// RQ15: Modulation bit 6 forces full-depth ASK whatever the conductance.
// RQ16: Reserved bits read zero and writes to them have no effect.
`timescale 1ns/1ns
module rrm_ctrl #(
  parameter bit NEW_REV = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic [rrm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [rrm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command engine
  input wire logic cmd_write,
  input wire logic [3:0] cmd_code,
  input wire logic rx_start,
  output logic rx_active,
  output logic rx_done,
  // Decoder side
  input wire rrm_pkg::rrm_frame_s frame_end,
  input wire logic [7:0] error_flags_reg,
  input wire logic crc_good_flag,
  output logic rx_crc_check_en,
  output rrm_pkg::rrm_rate_e rx_bit_rate,
  output rrm_pkg::rrm_fifo_s fifo_push,
  // Transmitter side
  input wire logic tx_envelope,
  input wire logic carrier,
  output rrm_pkg::rrm_drv_s drv,
  output logic force_full_depth_ask
);
  import rrm_pkg::*;

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta_r, rst_sync_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] rx_mode_r, drv_ctrl_r, tx_mod_r;

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[ADDR_W-1:2];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = word_index(addr);
    mapped = (idx == IDX_RX_MODE) || (idx == IDX_DRV_CTRL) ||
             (idx == IDX_TX_MOD) || (idx == IDX_RX_STATUS);
  endfunction

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic aw_held_r, w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstb_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [7:0] wr_idx = word_index(awaddr_r);
  wire wr_ok = mapped(awaddr_r);

  // Ready flags are flops, kept as the inverse of the held flags
  // Each channel stalls once its beat is held, until the response is raised
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_r <= '0;
      wbyte_r <= 8'h00;
      wstb_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wbyte_r <= s_axi_wdata[7:0];
        wstb_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_en = wr_fire && wstb_r;

  // RQ16 reserved bits masked
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_mode_r <= RST_RX_MODE;
      drv_ctrl_r <= RST_DRV_CTRL;
      tx_mod_r <= RST_TX_MOD;
    end else if (wr_en) begin
      if (wr_idx == IDX_RX_MODE) rx_mode_r <= wbyte_r & MASK_RX_MODE;
      if (wr_idx == IDX_DRV_CTRL) drv_ctrl_r <= wbyte_r & MASK_DRV_CTRL;
      if (wr_idx == IDX_TX_MOD) tx_mod_r <= wbyte_r & MASK_TX_MOD;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [7:0] status_byte;
  wire [7:0] rd_idx = word_index(s_axi_araddr);
  wire [7:0] rd_mux = (rd_idx == IDX_RX_MODE) ? rx_mode_r :
                      (rd_idx == IDX_DRV_CTRL) ? drv_ctrl_r :
                      (rd_idx == IDX_TX_MOD) ? tx_mod_r :
                      (rd_idx == IDX_RX_STATUS) ? status_byte : 8'h00;
  // One read in flight: address ready is the registered inverse of rvalid
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= {24'h00_0000, rd_mux};
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Receive-mode fields
  // ----------------------------------------
  wire multi_bit = rx_mode_r[RX_MULTI_BIT];
  wire short_ign = rx_mode_r[RX_SHORT_BIT];
  wire [2:0] rate_code = rx_mode_r[RX_RATE_HI:RX_RATE_LO];
  // RQ3 reserved codes flagged
  wire rate_bad = rate_code[2];
  // RQ2 CRC off only legal at 106
  wire crc_bad = !rx_mode_r[RX_CRC_BIT] && (rate_code != RATE_106);
  // RQ6 multi only above 106
  // Reserved codes run at 106, so multi is refused there as well
  wire multi_ok = multi_bit && !rate_bad && (rate_code != RATE_106);

  // RQ1 CRC check enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_crc_check_en <= 1'b0;
      rx_bit_rate <= RATE_106;
      force_full_depth_ask <= 1'b0;
    end else begin
      rx_crc_check_en <= rx_mode_r[RX_CRC_BIT];
      // RQ3 reserved code falls back
      rx_bit_rate <= rate_bad ? RATE_106 : rrm_rate_e'(rate_code);
      // RQ15 full depth ASK
      force_full_depth_ask <= tx_mod_r[ASK_FULL_BIT];
    end
  end

  // ----------------------------------------
  // Receive control
  // ----------------------------------------
  rrm_rx_e rx_state_r, rx_state_nxt;
  logic multi_seen_r;
  wire short_frame = frame_end.valid && (frame_end.nbits < 6'(MIN_FRAME_BITS));
  // RQ4 short streams dropped
  wire frame_taken = frame_end.valid && !(short_ign && short_frame);
  // RQ7 stop on other command
  wire cmd_stop = cmd_write && (cmd_code != CMD_RECEIVE);
  // RQ9 revision-dependent CRC bit
  wire [7:0] err_copy = NEW_REV ?
    {error_flags_reg[7:ERR_CRC_BIT+1], crc_good_flag, error_flags_reg[ERR_CRC_BIT-1:0]} :
    error_flags_reg;
  assign status_byte = {5'h00, crc_bad, rate_bad, rx_state_r != RX_IDLE};

  always_comb begin
    rx_state_nxt = rx_state_r;
    unique case (rx_state_r)
      RX_IDLE: begin
        if (rx_start) rx_state_nxt = RX_ACTIVE;
      end
      RX_ACTIVE: begin
        if (cmd_stop) rx_state_nxt = RX_IDLE;
        // RQ8 append error byte
        else if (frame_taken && multi_ok) rx_state_nxt = RX_APPEND;
        // RQ5 single frame stops
        else if (frame_taken) rx_state_nxt = RX_IDLE;
        // RQ7 clearing bit ends multi
        // Falling edge of the bit, against its copy one cycle back
        else if (multi_seen_r && !multi_bit) rx_state_nxt = RX_IDLE;
      end
      RX_APPEND: begin
        // RQ6 keep receiving
        rx_state_nxt = (cmd_stop || !multi_bit) ? RX_IDLE : RX_ACTIVE;
      end
      default: rx_state_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= RX_IDLE;
      rx_active <= 1'b0;
      rx_done <= 1'b0;
      fifo_push <= '0;
      multi_seen_r <= 1'b0;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_active <= rx_state_nxt != RX_IDLE;
      rx_done <= (rx_state_r != RX_IDLE) && (rx_state_nxt == RX_IDLE);
      multi_seen_r <= multi_bit;
      fifo_push.valid <= rx_state_nxt == RX_APPEND;
      fifo_push.data <= err_copy;
    end
  end

  // ----------------------------------------
  // Antenna drivers
  // ----------------------------------------
  wire a_en = drv_ctrl_r[DRV_A_EN];
  wire b_en = drv_ctrl_r[DRV_B_EN];
  // RQ14 A modulated carrier
  wire a_raw = a_en && carrier && tx_envelope;
  // RQ12 RQ13 B carrier, CW or modulated
  wire b_raw = b_en && carrier && (drv_ctrl_r[DRV_B_CW] || tx_envelope);
  // RQ10 RQ11 inversion by enable state
  wire a_inv = a_en ? drv_ctrl_r[DRV_A_INV_ON] : drv_ctrl_r[DRV_A_INV_OFF];
  wire b_inv = b_en ? drv_ctrl_r[DRV_B_INV_ON] : drv_ctrl_r[DRV_B_INV_OFF];

  // One cycle of latency keeps every pin registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drv <= '0;
    end else begin
      drv.a_on <= a_en;
      drv.b_on <= b_en;
      drv.a_out <= a_raw ^ a_inv;
      drv.b_out <= b_raw ^ b_inv;
    end
  end
endmodule

/* File: rrm_ctrl_props.sv */
/*
  Port checker for the receive-mode and driver bank.
  Assumes a bind by port name onto rrm_ctrl.
*/
`timescale 1ns/1ns
module rrm_ctrl_props (
  // Clock and bus
  input wire logic clock,
  input wire logic rstn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receiver
  input wire logic cmd_write,
  input wire logic [3:0] cmd_code,
  input wire logic rx_active,
  input wire logic rx_done,
  input wire logic crc_good_flag,
  input wire rrm_pkg::rrm_rate_e rx_bit_rate,
  input wire rrm_pkg::rrm_fifo_s fifo_push
);
  import rrm_pkg::*;
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  chk_r_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
  chk_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_hi_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_rate_ok: assert property (rx_bit_rate[2] == 1'b0)
    else $error("reserved rate code");
  chk_push_one: assert property (fifo_push.valid |=> !fifo_push.valid)
    else $error("push too long");
  chk_push_fast: assert property (fifo_push.valid |-> rx_bit_rate != RATE_106)
    else $error("append at lowest rate");
  chk_push_crc: assert property (
    fifo_push.valid |-> fifo_push.data[ERR_CRC_BIT] == $past(crc_good_flag))
    else $error("crc status wrong");
  chk_cmd_stop: assert property (
    cmd_write && cmd_code != CMD_RECEIVE && rx_active |-> ##[1:4] !rx_active)
    else $error("receive not ended");
  chk_done_off: assert property (rx_done |-> ##[0:1] !rx_active)
    else $error("receiver left on");
  cover property (fifo_push.valid);
  cover property (rx_done);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind rrm_ctrl rrm_ctrl_props u_props (.*);

/* File: rrm_card_model.sv */
/*
  Card side: reports received streams and error status.
  Assumes the bench calls send just after a rising edge.
*/
`timescale 1ns/1ns
module rrm_card_model (
  // Clock
  input wire logic clock,
  // Decoder reports
  output rrm_pkg::rrm_frame_s frame_end,
  output logic [7:0] error_flags_reg,
  output logic crc_good_flag
);
  import rrm_pkg::*;
  initial begin
    frame_end = '0;
    error_flags_reg = 8'h00;
    crc_good_flag = 1'b0;
  end
  // Gap sets how slowly the card answers
  task automatic send(input logic [5:0] n, input logic [7:0] e, input logic g, input int gap);
    error_flags_reg <= e;
    crc_good_flag <= g;
    repeat (gap + 1) @(posedge clock);
    frame_end <= {1'b1, n};
    @(posedge clock);
    // Stale count scrambled once the pulse is gone
    frame_end <= {1'b0, ~n};
    repeat (6) @(posedge clock);
  endtask
endmodule

/* File: test_rf_rx_mode_tx_driver_ctrl.sv */
/*
  Self-checking bench for the receive-mode and driver bank.
  Assumes the checker and card model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(nm, e, a) cmp(nm, 34'(e), 34'(a))
module test_rf_rx_mode_tx_driver_ctrl;
  import rrm_pkg::*;
  localparam logic [9:0] A_RXM = {IDX_RX_MODE, 2'b00};
  localparam logic [9:0] A_DRV = {IDX_DRV_CTRL, 2'b00};
  localparam logic [9:0] A_MOD = {IDX_TX_MOD, 2'b00};
  localparam logic [9:0] A_STA = {IDX_RX_STATUS, 2'b00};
  logic clock = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, cmd_write = 0, rx_start = 0;
  logic tx_envelope = 0, carrier = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, rx_active, rx_done, rx_crc_check_en;
  logic force_full_depth_ask, crc_good_flag;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, cmd_code = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, wq[$];
  logic [7:0] error_flags_reg, fq[$];
  logic [33:0] rq[$];
  logic [15:0] lf = 16'h06ec;
  rrm_rate_e rx_bit_rate;
  rrm_fifo_s fifo_push;
  rrm_drv_s drv;
  rrm_frame_s frame_end;
  int error_cnt = 0;
  int check_count = 0;
  rrm_ctrl #(.NEW_REV(1'b1)) DUT (.*);
  rrm_card_model u_card (.*);
  always #4 clock = ~clock;
  // ----------------
  // Shared tasks
  // ----------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] a);
    check_count++;
    if (a !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, a);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {lf, 8'h00, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic c, input logic [3:0] k);
    cmd_code <= k;
    cmd_write <= c;
    rx_start <= !c;
    @(posedge clock);
    cmd_write <= 1'b0;
    rx_start <= 1'b0;
    repeat (5) @(posedge clock);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) `CHK("bresp", wq.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) `CHK("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (fifo_push.valid) `CHK("fifo", fq.size() ? fq.pop_front() : 8'hxx, fifo_push.data);
  end
  // Whole run is near 320 cycles
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(A_RXM, {RESP_OKAY, 24'h0, RST_RX_MODE});
    rd(A_DRV, {RESP_OKAY, 24'h0, RST_DRV_CTRL});
    rd(A_MOD, {RESP_OKAY, 24'h0, RST_TX_MOD});
    `CHK("drv_rst", 4'h0, drv);
    wr(10'h3fc, 8'hff, RESP_SLVERR);
    rd(10'h3fc, {RESP_SLVERR, 32'h0});
    wr(A_RXM, 8'hbf, RESP_OKAY);
    rd(A_RXM, {RESP_OKAY, 32'hbc});
    for (int i = 0; i < 8; i++) begin
      logic [3:0] ex;
      lf = nxt(lf);
      tx_envelope <= lf[0];
      carrier <= lf[1];
      wr(A_MOD, lf[7:0], RESP_OKAY);
      rd(A_MOD, {RESP_OKAY, 24'h0, lf[7:0] & 8'h40});
      `CHK("ask", lf[6], force_full_depth_ask);
      wr(A_DRV, lf[15:8], RESP_OKAY);
      rd(A_DRV, {RESP_OKAY, 24'h0, lf[15:8] & 8'hfb});
      // Pin is carrier gated by enable and envelope (envelope or CW bit for B), then inverted per state
      ex[3:2] = {lf[8], lf[9]};
      ex[1] = (lf[8] & lf[1] & lf[0]) ^ (lf[8] ? lf[14] : lf[12]);
      ex[0] = (lf[9] & lf[1] & (lf[11] | lf[0])) ^ (lf[9] ? lf[15] : lf[13]);
      `CHK("drv", ex, drv);
    end
    carrier <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(A_DRV, {k[0], 7'h0a}, RESP_OKAY);
      `CHK("cw", !k[0], drv.b_out);
    end
    carrier <= 1'b0;
    // CRC stays on above the lowest rate
    for (int c = 0; c < 8; c++) begin
      wr(A_RXM, {c != 0, c[2:0], 4'h0}, RESP_OKAY);
      `CHK("rate", c < 4 ? c[2:0] : 3'h0, rx_bit_rate);
      rd(A_STA, {RESP_OKAY, 24'h0, 5'h00, 1'b0, c >= 4, 1'b0});
      `CHK("crc_en", c != 0, rx_crc_check_en);
    end
    wr(A_RXM, 8'h08, RESP_OKAY);
    pulse(1'b0, 4'h0);
    u_card.send(6'd3, 8'h00, 1'b0, 2);
    `CHK("short", 1'b1, rx_active);
    u_card.send(6'd8, 8'h00, 1'b0, 9);
    `CHK("single", 1'b0, rx_active);
    wr(A_RXM, 8'h94, RESP_OKAY);
    pulse(1'b0, 4'h0);
    for (int k = 0; k < 3; k++) begin
      lf = nxt(lf);
      fq.push_back({lf[7:2], lf[8], lf[0]});
      u_card.send(6'd8, lf[7:0], lf[8], k);
      `CHK("multi", 1'b1, rx_active);
    end
    pulse(1'b1, CMD_RECEIVE);
    `CHK("recv_cmd", 1'b1, rx_active);
    pulse(1'b1, 4'h0);
    `CHK("idle_cmd", 1'b0, rx_active);
    pulse(1'b0, 4'h0);
    wr(A_RXM, 8'h90, RESP_OKAY);
    `CHK("multi_clr", 1'b0, rx_active);
    wr(A_RXM, 8'h04, RESP_OKAY);
    pulse(1'b0, 4'h0);
    u_card.send(6'd8, 8'h55, 1'b1, 0);
    `CHK("multi_106", 1'b0, rx_active);
    `CHK("left", 0, fq.size());
    end_of_test();
  end
endmodule
